// ===== rtl/led_plane_ctrl.sv
// brightness pwm, grayscale frame modulation, pointers and plane sequencer
`timescale 1ns/1ps
`include "led_plane_params.svh"

module led_plane_ctrl
  import led_plane_pkg::*;
#(
  parameter bit          GRAY_SUPPORT  = 1'b1,
  parameter int unsigned DIGIT_CYCLES  = `DIGIT_CYCLES,
  parameter int unsigned SECOND_CYCLES = `SECOND_CYCLES
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  // register access from the serial decoder
  input  wire reg_req_s         i_req,
  input  wire logic             i_cs_rise,
  input  wire logic             i_mem_byte_stb,
  output logic       [7:0]      o_rd_data,
  output logic                  o_rd_valid,
  // pointers and plane state
  output logic       [7:0]      o_drv_ptr,
  output logic       [13:0]     o_mem_ptr,
  output logic       [1:0]      o_plane,
  output logic                  o_gray_mode,
  // multiplex drive
  output logic                  o_digit_sel,
  output logic       [1:0]      o_digit_on,
  output logic       [1:0][3:0] o_lvl_on
);

  ////////////////////////////////////////////////////////////////////////
  // slot length rounds down, so the digit period may run slightly short
  localparam int unsigned SLOT_RAW = DIGIT_CYCLES / 256;
  localparam int unsigned SLOT_CYCLES = (SLOT_RAW < 1) ? 1 : SLOT_RAW;
  localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYCLES - 1);
  localparam logic [31:0] SEC_CYC = 32'(SECOND_CYCLES);
  localparam logic [31:0] SEC_LAST = 32'(SECOND_CYCLES - 1);

  plane_state_s st_r;
  plane_state_s st_nxt;

  // frame pattern for a 2-bit level of one digit
  function automatic logic level_lit(input logic [3:0] frame, input logic geo,
                                     input logic [1:0] lvl);
    logic [11:0] hi;
    logic [11:0] lo;
    hi = geo ? `PAT_GEO_HI : `PAT_ARITH_HI;
    lo = geo ? `PAT_GEO_LO : `PAT_ARITH_LO;
    case (lvl)
      2'd0:    level_lit = 1'b0;
      2'd1:    level_lit = lo[frame];
      2'd2:    level_lit = hi[frame];
      2'd3:    level_lit = 1'b1;
      default: level_lit = 1'b0;
    endcase
  endfunction

  // next plane in auto sequence, wrapping to the available count
  function automatic logic [1:0] plane_step(input logic [1:0] p, input logic two);
    plane_step = two ? {1'b0, ~p[0]} : 2'(p + 2'd1);
  endfunction

  // write strobe aimed at one register
  function automatic logic wr_hit(input reg_req_s r, input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // manual plane choice; with two planes the upper code bit is dropped
  function automatic logic [1:0] manual_plane(input logic [7:0] cfg, input logic two);
    manual_plane = two ? {1'b0, cfg[0]} : cfg[1:0];
  endfunction

  // scratch values of the combinational pass
  logic [7:0]  panel_eff;
  logic [15:0] prod;
  logic [7:0]  duty;
  logic [7:0]  slot_ofs;
  logic        step;
  logic [31:0] acc_add;
  seq_mode_e   mode;

  always_comb begin
    st_nxt = st_r;
    panel_eff = 8'h00;
    prod = 16'h0000;
    duty = 8'h00;
    slot_ofs = 8'h00;
    step = 1'b0;
    acc_add = 32'h0;
    mode = SEQ_MANUAL;

    // a low clock enable freezes everything, the read strobe included
    if (i_ce) begin
      st_nxt.rd_valid = 1'b0;
      //////////////////////////////////////////////////////////////////////
      // register writes
      if (i_req.wr) begin
        case (i_req.addr)
          `ADDR_PANEL_BRIGHT: st_nxt.panel = i_req.data;
          `ADDR_DIGIT0_INT:   st_nxt.digit_int[0] = i_req.data;
          `ADDR_DIGIT1_INT:   st_nxt.digit_int[1] = i_req.data;
          // variants without grayscale keep the bit at zero
          `ADDR_PANEL_CFG:    st_nxt.gray_mode = GRAY_SUPPORT & i_req.data[`CFG_GRAY_BIT];
          `ADDR_PIX_SCALE:    st_nxt.gray_geo = i_req.data[1:0];
          `ADDR_TARGET_DRV:   st_nxt.drv_ptr = i_req.data;
          `ADDR_PLANE_SEQ: begin
            st_nxt.seq_pend = i_req.data;
            st_nxt.pend_vld = 1'b1;
          end
          default: ;
        endcase
      end

      // a pointer write beats an increment in the same cycle
      if (wr_hit(i_req, `ADDR_FRAME_PTR_LO)) begin
        st_nxt.mem_ptr[7:0] = i_req.data;
      end else if (wr_hit(i_req, `ADDR_FRAME_PTR_HI)) begin
        st_nxt.mem_ptr[13:8] = i_req.data[5:0];
      end else if (i_mem_byte_stb) begin
        st_nxt.mem_ptr = 14'(st_r.mem_ptr + 14'd1);
      end

      //////////////////////////////////////////////////////////////////////
      // register reads
      // reads see the state before any write of the same cycle
      if (i_req.rd) begin
        st_nxt.rd_valid = 1'b1;
        case (i_req.addr)
          `ADDR_PANEL_BRIGHT: st_nxt.rd_data = st_r.panel;
          `ADDR_DIGIT0_INT:   st_nxt.rd_data = st_r.digit_int[0];
          `ADDR_DIGIT1_INT:   st_nxt.rd_data = st_r.digit_int[1];
          `ADDR_PANEL_CFG: begin
            st_nxt.rd_data = 8'h00;
            st_nxt.rd_data[`CFG_GRAY_BIT] = st_r.gray_mode;
            st_nxt.rd_data[`CFG_PLANE_LSB +: 2] = st_r.plane;
          end
          `ADDR_PIX_SCALE:    st_nxt.rd_data = {6'h00, st_r.gray_geo};
          `ADDR_TARGET_DRV:   st_nxt.rd_data = st_r.drv_ptr;
          `ADDR_FRAME_PTR_LO: st_nxt.rd_data = st_r.mem_ptr[7:0];
          `ADDR_FRAME_PTR_HI: st_nxt.rd_data = {2'b00, st_r.mem_ptr[13:8]};
          `ADDR_PLANE_SEQ:    st_nxt.rd_data = st_r.seq_cfg;
          default:            st_nxt.rd_data = 8'h00;
        endcase
      end

      //////////////////////////////////////////////////////////////////////
      // plane sequencer
      // fast bit without the auto bit still means manual
      mode = seq_mode_e'({st_r.seq_cfg[`SEQ_FAST_BIT], st_r.seq_cfg[`SEQ_AUTO_BIT]});
      if (!st_r.seq_cfg[`SEQ_AUTO_BIT]) begin
        mode = SEQ_MANUAL;
      end else if (!st_r.seq_cfg[`SEQ_FAST_BIT]) begin
        mode = SEQ_SLOW;
      end
      case (mode)
        SEQ_SLOW: begin
          // count whole seconds, then N of them
          if (st_r.sec_acc >= SEC_LAST) begin
            st_nxt.sec_acc = 32'h0;
            if (6'(st_r.sec_cnt + 6'd1) >= st_r.seq_cfg[5:0]) begin
              st_nxt.sec_cnt = 6'h00;
              // a zero count never steps, so the plane stays put
              step = (st_r.seq_cfg[5:0] != 6'h00);
            end else begin
              st_nxt.sec_cnt = 6'(st_r.sec_cnt + 6'd1);
            end
          end else begin
            st_nxt.sec_acc = 32'(st_r.sec_acc + 32'd1);
          end
        end
        SEQ_FAST: begin
          // rate accumulator spreads N steps evenly over one second
          acc_add = 32'(st_r.sec_acc + {26'h0, st_r.seq_cfg[5:0]});
          if (acc_add >= SEC_CYC) begin
            st_nxt.sec_acc = 32'(acc_add - SEC_CYC);
            step = 1'b1;
          end else begin
            st_nxt.sec_acc = acc_add;
          end
        end
        SEQ_MANUAL: begin
          st_nxt.sec_acc = 32'h0;
          st_nxt.sec_cnt = 6'h00;
          st_nxt.plane = manual_plane(st_r.seq_cfg, st_r.gray_mode);
        end
        default: st_nxt.sec_acc = 32'h0;
      endcase
      if (step) begin
        st_nxt.plane = plane_step(st_r.plane, st_r.gray_mode);
      end
      if (mode != SEQ_MANUAL && st_r.gray_mode) begin
        st_nxt.plane[1] = 1'b0;
      end

      // new setting becomes live at the end of the transmission
      if (i_cs_rise && st_r.pend_vld) begin
        st_nxt.seq_cfg = st_r.seq_pend;
        st_nxt.pend_vld = 1'b0;
        st_nxt.sec_acc = 32'h0;
        st_nxt.sec_cnt = 6'h00;
        // entering auto always restarts from plane 0
        if (st_r.seq_pend[`SEQ_AUTO_BIT]) begin
          st_nxt.plane = 2'b00;
        end else begin
          st_nxt.plane = manual_plane(st_r.seq_pend, st_r.gray_mode);
        end
      end
      // a write landing with the commit edge stays pending for the next one
      if (wr_hit(i_req, `ADDR_PLANE_SEQ)) begin
        st_nxt.pend_vld = 1'b1;
      end

      //////////////////////////////////////////////////////////////////////
      // multiplex timebase: 256 slots per digit period
      if (st_r.slot_pre >= SLOT_LAST) begin
        st_nxt.slot_pre = 16'h0000;
        st_nxt.slot = 8'(st_r.slot + 8'd1);
        if (st_r.slot == 8'hff) begin
          st_nxt.digit_sel = ~st_r.digit_sel;
          // frame steps once both digits have shown
          if (st_r.digit_sel) begin
            st_nxt.frame = (st_r.frame == `FRAME_LAST) ? 4'h0 : 4'(st_r.frame + 4'd1);
          end
        end
      end else begin
        st_nxt.slot_pre = 16'(st_r.slot_pre + 16'd1);
      end

      // codes at or below the minimum all give the 2/256 floor
      panel_eff = (st_r.panel <= `PANEL_MIN_CODE) ? `PANEL_MIN_CODE : st_r.panel;
      prod = st_nxt.digit_sel ? st_r.digit_int[1] * panel_eff
                              : st_r.digit_int[0] * panel_eff;
      duty = prod[15:8];
      // two dark slots lead and two trail, so four between digits;
      // duties above 252 give up their top steps to keep that gap
      slot_ofs = 8'(st_nxt.slot - `BLANK_LEAD_SLOTS);
      st_nxt.digit_on = 2'b00;
      if (st_nxt.slot >= `BLANK_LEAD_SLOTS && slot_ofs < duty &&
          st_nxt.slot <= 8'(8'hff - `BLANK_LEAD_SLOTS)) begin
        st_nxt.digit_on[st_nxt.digit_sel] = 1'b1;
      end

      //////////////////////////////////////////////////////////////////////
      // grayscale frame modulation per digit
      // without grayscale every lit level shows in every frame
      for (int d = 0; d < 2; d++) begin
        for (int l = 0; l < 4; l++) begin
          if (st_r.gray_mode) begin
            st_nxt.lvl_on[d][l] = level_lit(st_nxt.frame, st_r.gray_geo[d], 2'(l));
          end else begin
            st_nxt.lvl_on[d][l] = (l != 0);
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset ignores the clock enable so a frozen block can still be cleared
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output is a flop of the state record
  assign o_rd_data   = st_r.rd_data;
  assign o_rd_valid  = st_r.rd_valid;
  assign o_drv_ptr   = st_r.drv_ptr;
  assign o_mem_ptr   = st_r.mem_ptr;
  assign o_plane     = st_r.plane;
  assign o_gray_mode = st_r.gray_mode;
  assign o_digit_sel = st_r.digit_sel;
  assign o_digit_on  = st_r.digit_on;
  assign o_lvl_on    = st_r.lvl_on;

endmodule

// ===== rtl/led_plane_params.svh
// offsets, field positions, reset values and timing counts of the plane control block
`ifndef LED_PLANE_PARAMS_SVH
`define LED_PLANE_PARAMS_SVH
`define ADDR_PANEL_BRIGHT   8'h02
`define ADDR_DIGIT0_INT     8'h03
`define ADDR_DIGIT1_INT     8'h04
`define ADDR_TARGET_DRV     8'h08
`define ADDR_FRAME_PTR_LO   8'h09
`define ADDR_FRAME_PTR_HI   8'h0a
`define ADDR_PLANE_SEQ      8'h0b
`define ADDR_PANEL_CFG      8'h0d
`define ADDR_PIX_SCALE      8'h0e
`define CFG_GRAY_BIT        7
`define CFG_PLANE_LSB       2
`define SEQ_FAST_BIT        7
`define SEQ_AUTO_BIT        6
`define PANEL_MIN_CODE      8'h02
`define REG_RESET           8'h00
`define FRAME_LAST          4'hb
`define BLANK_LEAD_SLOTS    8'h02
`define PAT_ARITH_HI        12'hb6d
`define PAT_ARITH_LO        12'h492
`define PAT_GEO_HI          12'h555
`define PAT_GEO_LO          12'h222
`define CLK_PERIOD_NS       10
`define DIGIT_PERIOD_NS     122000
`define SECOND_NS           1000000000
`define DIGIT_CYCLES        (`DIGIT_PERIOD_NS / `CLK_PERIOD_NS)
`define SECOND_CYCLES       (`SECOND_NS / `CLK_PERIOD_NS)
`endif

// ===== rtl/led_plane_pkg.sv
// types shared by the plane control block
package led_plane_pkg;
  typedef enum logic [1:0] {
    SEQ_MANUAL = 2'b00,
    SEQ_SLOW   = 2'b01,
    SEQ_FAST   = 2'b11
  } seq_mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_s;

  typedef struct packed {
    logic [7:0]      panel;
    logic [1:0][7:0] digit_int;
    logic [1:0]      gray_geo;
    logic            gray_mode;
    logic [7:0]      drv_ptr;
    logic [13:0]     mem_ptr;
    logic [7:0]      seq_cfg;
    logic [7:0]      seq_pend;
    logic            pend_vld;
    logic [1:0]      plane;
    logic [31:0]     sec_acc;
    logic [5:0]      sec_cnt;
    logic [15:0]     slot_pre;
    logic [7:0]      slot;
    logic            digit_sel;
    logic [3:0]      frame;
    logic [1:0]      digit_on;
    logic [1:0][3:0] lvl_on;
    logic [7:0]      rd_data;
    logic            rd_valid;
  } plane_state_s;
endpackage

// ===== dv/led_plane_props.sv
// port assertions for the plane control block
`timescale 1ns/1ps
module led_plane_props
  import led_plane_pkg::*;
(
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_ce,
  input  wire reg_req_s        i_req,
  input  wire logic            i_mem_byte_stb,
  input  wire logic            o_rd_valid,
  input  wire logic [7:0]      o_drv_ptr,
  input  wire logic [13:0]     o_mem_ptr,
  input  wire logic [1:0]      o_plane,
  input  wire logic            o_gray_mode,
  input  wire logic            o_digit_sel,
  input  wire logic [1:0]      o_digit_on,
  input  wire logic [1:0][3:0] o_lvl_on
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic        ptr_wr;
  logic [13:0] ptr_inc;
  // a pointer write beats the byte strobe
  assign ptr_wr  = i_req.wr && (i_req.addr inside {8'h09, 8'h0a});
  assign ptr_inc = o_mem_ptr + 14'h0001;
  ////////////////////////////////////////////////////////////////////////
  a_rd_answer: assert property (i_ce && i_req.rd |=> o_rd_valid)
    else $error("read not answered");
  a_ptr_step: assert property (i_ce && i_mem_byte_stb && !ptr_wr |=>
    o_mem_ptr == $past(ptr_inc)) else $error("frame pointer step wrong");
  a_drv_load: assert property (i_ce && i_req.wr && i_req.addr == 8'h08 |=>
    o_drv_ptr == $past(i_req.data)) else $error("driver pointer not loaded");
  a_ptr_high: assert property (i_ce && i_req.wr && i_req.addr == 8'h0a |=>
    o_mem_ptr[13:8] == $past(i_req.data[5:0])) else $error("pointer high wrong");
  a_one_digit: assert property (o_digit_on != 2'b00 |->
    o_digit_on == (2'b01 << o_digit_sel)) else $error("wrong digit driven");
  a_blank_gap: assert property ($changed(o_digit_sel) |->
    $past(o_digit_on) == 2'b00 && $past(o_digit_on, 2) == 2'b00 ##0
    (o_digit_on == 2'b00) [*3]) else $error("no blanking at digit change");
  a_plain_levels: assert property (!o_gray_mode && $past(!o_gray_mode) &&
    $past(i_rst_n) |-> o_lvl_on == {2{4'b1110}}) else $error("plain levels wrong");
  a_two_planes: assert property (o_gray_mode && $past(o_gray_mode) |->
    !o_plane[1]) else $error("plane beyond two in grayscale");
  c_gray_lit: cover property (o_gray_mode && o_digit_on != 2'b00);
  c_ptr_wrap: cover property (i_mem_byte_stb && o_mem_ptr == 14'h3fff);
  c_plane_back: cover property ($changed(o_plane) && o_plane == 2'h0);
endmodule

bind led_plane_ctrl led_plane_props u_props (.i_sys_clk, .i_rst_n, .i_ce, .i_req,
  .i_mem_byte_stb, .o_rd_valid, .o_drv_ptr, .o_mem_ptr, .o_plane, .o_gray_mode,
  .o_digit_sel, .o_digit_on, .o_lvl_on);

// ===== dv/host_model.sv
// host side of the serial register link, one request at a time
`timescale 1ns/1ps
module host_model
  import led_plane_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output reg_req_s        o_req,
  output logic            o_cs_rise,
  output logic            o_byte_stb
);
  initial begin
    o_req = '0;
    o_cs_rise = 1'b0;
    o_byte_stb = 1'b0;
  end
  // released fields show the inverse so stale values never match
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_req = '{w, !w, a, d};
    @(posedge i_sys_clk);
    #1;
    o_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    put(1'b0, a, 8'h00);
    ok = (i_rd_valid === 1'b1);
    d = i_rd_data;
  endtask
  task automatic pulse(input bit cs);
    @(posedge i_sys_clk);
    #1;
    if (cs) o_cs_rise = 1'b1; else o_byte_stb = 1'b1;
    @(posedge i_sys_clk);
    #1;
    o_cs_rise = 1'b0;
    o_byte_stb = 1'b0;
  endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the plane control block
`timescale 1ns/1ps
module tb_top
  import led_plane_pkg::*;
;
  localparam int SEC = 1000;
  logic            i_sys_clk = 1'b0;
  logic            i_rst_n = 1'b0;
  logic            i_ce = 1'b1;
  reg_req_s        req;
  logic            cs_rise, stb, rd_valid, gray, gray_ng;
  logic [7:0]      rd_data, a, d, p, n0, n1;
  logic [13:0]     mptr;
  logic [1:0]      plane, don, prev;
  logic [1:0][3:0] lvl;
  int              n_errors = 0, checks = 0, on0, on1, per, cnt[2][4];
  always #5 i_sys_clk = ~i_sys_clk;
  led_plane_ctrl #(.DIGIT_CYCLES(512), .SECOND_CYCLES(SEC)) DUT (.i_sys_clk, .i_rst_n,
    .i_ce, .i_req(req), .i_cs_rise(cs_rise), .i_mem_byte_stb(stb), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_drv_ptr(), .o_mem_ptr(mptr), .o_plane(plane),
    .o_gray_mode(gray), .o_digit_sel(), .o_digit_on(don), .o_lvl_on(lvl));
  // variant without grayscale, fed the same requests
  led_plane_ctrl #(.GRAY_SUPPORT(1'b0), .DIGIT_CYCLES(512), .SECOND_CYCLES(SEC))
    dut_no_gray (.i_sys_clk, .i_rst_n, .i_ce, .i_req(req), .i_cs_rise(cs_rise),
    .i_mem_byte_stb(stb), .o_rd_data(), .o_rd_valid(), .o_drv_ptr(), .o_mem_ptr(),
    .o_plane(), .o_gray_mode(gray_ng), .o_digit_sel(), .o_digit_on(), .o_lvl_on());
  host_model host (.i_sys_clk, .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_req(req),
    .o_cs_rise(cs_rise), .o_byte_stb(stb));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] dd);
    host.put(1'b1, ad, dd);
  endtask
  task automatic rdc(logic [7:0] ad, logic [7:0] exp);
    logic [7:0] v;
    bit ok;
    host.rd(ad, v, ok);
    if (!ok) begin
      n_errors++;
      summarize();
    end
    check("read", v, exp);
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // slot is two clocks with the shortened digit period
  // capped so that four dark slots always separate the digits
  function automatic int duty(logic [7:0] n, logic [7:0] pp);
    int r;
    r = (int'(n) * (pp < 8'h02 ? 2 : int'(pp))) >> 8;
    return r > 252 ? 252 : r;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] tbl[7] = '{8'h02, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0a, 8'h05};
    logic [7:0] cfg[4] = '{8'h41, 8'h42, 8'hc1, 8'hc4};
    int ex[2][4] = '{'{0, 3, 6, 12}, '{0, 4, 8, 12}};
    void'($urandom(28));
    repeat (5) @(posedge i_sys_clk);
    #1 i_rst_n = 1'b1;
    foreach (tbl[i]) begin
      a = tbl[i];
      d = 8'($urandom);
      rdc(a, 8'h00);
      wr(a, d);
      rdc(a, a == 8'h05 ? 8'h00 : (a == 8'h0a ? d & 8'h3f : d));
    end
    wr(8'h09, 8'hff);
    wr(8'h0a, 8'hff);
    check("ptr", 16'(mptr), 16'h3fff);
    host.pulse(1'b0);
    check("ptr wrap", 16'(mptr), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      p = i == 3 ? 8'($urandom) : (i == 0 ? 8'hff : 8'(i - 1));
      n0 = i == 3 ? 8'($urandom) : 8'hff;
      n1 = i == 3 ? 8'($urandom) : (i == 0 ? 8'h80 : 8'h01);
      wr(8'h02, p);
      wr(8'h03, n0);
      wr(8'h04, n1);
      cyc(1024);
      on0 = 0;
      on1 = 0;
      repeat (1024) begin
        cyc(1);
        on0 += don[0];
        on1 += don[1];
      end
      check("on0", 16'(on0), 16'(2 * duty(n0, p)));
      check("on1", 16'(on1), 16'(2 * duty(n1, p)));
    end
    prev = 2'h0;
    for (int g = 1; g >= 0; g--) begin
      wr(8'h0d, 8'(g << 7));
      check("gray", 16'(gray), 16'(g));
      check("no gray", 16'(gray_ng), 16'h0000);
      for (int v = 0; v < 4; v++) begin
        wr(8'h0b, 8'(v));
        check("hold", 16'(plane), 16'(g ? prev & 2'h1 : prev));
        host.pulse(1'b1);
        cyc(1);
        prev = 2'(v);
        check("manual", 16'(plane), 16'(g ? prev & 2'h1 : prev));
        rdc(8'h0d, 8'(g << 7) | {4'h0, (g ? prev & 2'h1 : prev), 2'h0});
        rdc(8'h0b, 8'(v));
      end
    end
    foreach (cfg[i]) begin
      per = cfg[i][7] ? SEC / cfg[i][5:0] : SEC * cfg[i][5:0];
      wr(8'h0b, cfg[i]);
      host.pulse(1'b1);
      for (int k = 0; k < 5; k++) begin
        cyc(k == 0 ? per / 2 : per);
        check("auto", 16'(plane), 16'(k % 4));
      end
    end
    wr(8'h0b, 8'h00);
    host.pulse(1'b1);
    wr(8'h0d, 8'h80);
    wr(8'h0e, 8'h01);
    cnt = '{default: 0};
    repeat (12) begin
      cyc(1024);
      foreach (cnt[x, y]) cnt[x][y] += lvl[x][y];
    end
    foreach (cnt[x, y]) check("levels", 16'(cnt[x][y]), 16'(ex[x][y]));
    summarize();
  end
endmodule
